// ==== inc/rxis_pkg.sv ====
/*
 * rxis_pkg: shared constants and carriers for the receiver interrupt
 * status latches. Assumes an 8-bit register port with byte offsets.
 */
`default_nettype none

package rxis_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register port geometry
    localparam int unsigned RXIS_ADDR_W = 8;
    localparam int unsigned RXIS_DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // status registers (read only)
    localparam logic [7:0] RXIS_OFF_LVL3_STATUS = 8'h6b;
    localparam logic [7:0] RXIS_OFF_LVL4_STATUS = 8'h70;
    localparam logic [7:0] RXIS_OFF_EDGE1_STATUS = 8'h7a;

    // live level readback (read only)
    localparam logic [7:0] RXIS_OFF_LVL3_LIVE = 8'h6a;
    localparam logic [7:0] RXIS_OFF_LVL4_LIVE = 8'h6f;

    // clear registers (write only, write one to clear)
    localparam logic [7:0] RXIS_OFF_LVL3_CLEAR = 8'h6c;
    localparam logic [7:0] RXIS_OFF_LVL4_CLEAR = 8'h71;
    localparam logic [7:0] RXIS_OFF_EDGE1_CLEAR = 8'h7b;

    // enable masks for the primary interrupt output
    localparam logic [7:0] RXIS_OFF_LVL3_MASK1 = 8'h6d;
    localparam logic [7:0] RXIS_OFF_LVL4_MASK1 = 8'h72;
    localparam logic [7:0] RXIS_OFF_EDGE1_MASK1 = 8'h7c;

    // enable masks for the secondary interrupt output
    localparam logic [7:0] RXIS_OFF_LVL3_MASK2 = 8'h6e;
    localparam logic [7:0] RXIS_OFF_LVL4_MASK2 = 8'h73;
    localparam logic [7:0] RXIS_OFF_EDGE1_MASK2 = 8'h7d;

    ////////////////////////////////////////////////////////////////////////
    // implemented bits per register; the rest are reserved and read zero
    localparam logic [7:0] RXIS_LVL3_VALID = 8'h3f;
    localparam logic [7:0] RXIS_LVL4_VALID = 8'h07;
    localparam logic [7:0] RXIS_EDGE1_VALID = 8'hc0;

    // field positions
    localparam int unsigned RXIS_POS_PLL_B = 5;
    localparam int unsigned RXIS_POS_CLK_A = 4;
    localparam int unsigned RXIS_POS_CLK_B = 3;
    localparam int unsigned RXIS_POS_STEREO = 2;
    localparam int unsigned RXIS_POS_VSYNC = 1;
    localparam int unsigned RXIS_POS_REGEN = 0;
    localparam int unsigned RXIS_POS_ENCR_A = 2;
    localparam int unsigned RXIS_POS_ENCR_B = 1;
    localparam int unsigned RXIS_POS_CABLE_A = 0;
    localparam int unsigned RXIS_POS_CODE2 = 7;
    localparam int unsigned RXIS_POS_CODE1 = 6;

    // reset values
    localparam logic [7:0] RXIS_RST_STATUS = 8'h00;
    localparam logic [7:0] RXIS_RST_MASK = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // live level conditions, packed in register bit order
    typedef struct packed {
        logic port_a_encryption_live;
        logic port_b_encryption_live;
        logic port_a_cable_present_live;
        logic port_b_pll_lock_live;
        logic port_a_clock_detect_live;
        logic port_b_clock_detect_live;
        logic stereo_video_live;
        logic vsync_filter_lock_live;
        logic enable_regen_lock_live;
    } rxis_level_s;

    // one-cycle new-content packet pulses
    typedef struct packed {
        logic second_recording_code_pkt_new;
        logic first_recording_code_pkt_new;
    } rxis_packet_s;

endpackage

`default_nettype wire

// ==== design/rxis_status_latches.sv ====
/*
 * rxis_status_latches: sticky interrupt status bits for link lock, clock
 * detect, stereo video, sync locks, encryption, cable and recording-code
 * packets, with clear, two enable masks and two level interrupt outputs.
 * Assumes live levels and packet pulses come from logic on ref_clk_i and
 * a register master that never waits.
 */
// What this block does
// [R1] latch port b pll lock change, 0x6B[5]
// [R2] latch port a clock detect change, 0x6B[4]
// [R3] latch port b clock detect change, 0x6B[3]
// [R4] latch stereo video change, 0x6B[2]
// [R5] latch vsync filter lock change, 0x6B[1]
// [R6] latch enable regen lock change, 0x6B[0]
// [R7] latch port a encryption change, 0x70[2]
// [R8] latch port b encryption change, 0x70[1]
// [R9] latch port a cable change, 0x70[0]
// [R10] set on new second code packet, 0x7A[7]
// [R11] set on new first code packet, 0x7A[6]
// [R12] bits hold until cleared; reads never clear
// [R13] bits count only when a mask enables
// [R14] level changes detected in both directions
// [R15] clear takes next edge; set beats clear
`timescale 1ns/1ps
`default_nettype none

module rxis_status_latches (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire rxis_pkg::rxis_level_s level_live_i,
    input wire rxis_pkg::rxis_packet_s packet_new_i,
    input wire logic [rxis_pkg::RXIS_ADDR_W-1:0] reg_addr_i,
    input wire logic [rxis_pkg::RXIS_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [rxis_pkg::RXIS_DATA_W-1:0] reg_rdata_o,
    output logic interrupt_output_primary_o,
    output logic interrupt_output_secondary_o
);
    import rxis_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic armed;
    rxis_level_s level_prev;
    logic [8:0] level_change;
    logic [7:0] lvl3_set;
    logic [7:0] lvl4_set;
    logic [7:0] edge1_set;
    logic [7:0] lvl3_clr;
    logic [7:0] lvl4_clr;
    logic [7:0] edge1_clr;
    logic [7:0] lvl3_status;
    logic [7:0] lvl4_status;
    logic [7:0] edge1_status;
    logic [7:0] lvl3_mask1;
    logic [7:0] lvl4_mask1;
    logic [7:0] edge1_mask1;
    logic [7:0] lvl3_mask2;
    logic [7:0] lvl4_mask2;
    logic [7:0] edge1_mask2;
    logic [7:0] next_rdata;

    // write-one-to-clear decode, limited to implemented bits
    function automatic logic [7:0] wr_hit(
        input logic wr,
        input logic [7:0] addr,
        input logic [7:0] off,
        input logic [7:0] data,
        input logic [7:0] valid
    );
        wr_hit = (wr && addr == off) ? (data & valid) : 8'h00;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // change detection
    // the first cycle after reset only loads the history, so a level that is
    // already high at release does not raise a false event
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            level_prev <= '0;
        end else begin
            level_prev <= level_live_i;
        end
    end

    // xor catches rising and falling alike; see [R14]
    assign level_change = armed ? (level_live_i ^ level_prev) : 9'h000;

    // map changes onto register bit positions; see [R1] [R2] [R3] [R4] [R5] [R6]
    assign lvl3_set = {2'b00, level_change[5:0]};
    // see [R7] [R8] [R9]
    assign lvl4_set = {5'b00000, level_change[8:6]};
    // packet pulses count only once armed; see [R10] [R11]
    assign edge1_set = armed ? {packet_new_i, 6'b000000} : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // clear strobes from the register port
    assign lvl3_clr = wr_hit(reg_wr_i, reg_addr_i, RXIS_OFF_LVL3_CLEAR, reg_wdata_i, RXIS_LVL3_VALID);
    assign lvl4_clr = wr_hit(reg_wr_i, reg_addr_i, RXIS_OFF_LVL4_CLEAR, reg_wdata_i, RXIS_LVL4_VALID);
    assign edge1_clr = wr_hit(reg_wr_i, reg_addr_i, RXIS_OFF_EDGE1_CLEAR, reg_wdata_i, RXIS_EDGE1_VALID);

    ////////////////////////////////////////////////////////////////////////
    // sticky status; set is or-ed after the clear so it wins
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            lvl3_status <= RXIS_RST_STATUS;
            lvl4_status <= RXIS_RST_STATUS;
            edge1_status <= RXIS_RST_STATUS;
        end else begin
            lvl3_status <= (lvl3_status & ~lvl3_clr) | lvl3_set; // see [R12] [R15]
            lvl4_status <= (lvl4_status & ~lvl4_clr) | lvl4_set; // see [R12] [R15]
            edge1_status <= (edge1_status & ~edge1_clr) | edge1_set; // see [R12] [R15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable masks, one set per interrupt output
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            lvl3_mask1 <= RXIS_RST_MASK;
            lvl4_mask1 <= RXIS_RST_MASK;
            edge1_mask1 <= RXIS_RST_MASK;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                RXIS_OFF_LVL3_MASK1: begin
                    lvl3_mask1 <= reg_wdata_i & RXIS_LVL3_VALID;
                end
                RXIS_OFF_LVL4_MASK1: begin
                    lvl4_mask1 <= reg_wdata_i & RXIS_LVL4_VALID;
                end
                RXIS_OFF_EDGE1_MASK1: begin
                    edge1_mask1 <= reg_wdata_i & RXIS_EDGE1_VALID;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            lvl3_mask2 <= RXIS_RST_MASK;
            lvl4_mask2 <= RXIS_RST_MASK;
            edge1_mask2 <= RXIS_RST_MASK;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                RXIS_OFF_LVL3_MASK2: begin
                    lvl3_mask2 <= reg_wdata_i & RXIS_LVL3_VALID;
                end
                RXIS_OFF_LVL4_MASK2: begin
                    lvl4_mask2 <= reg_wdata_i & RXIS_LVL4_VALID;
                end
                RXIS_OFF_EDGE1_MASK2: begin
                    edge1_mask2 <= reg_wdata_i & RXIS_EDGE1_VALID;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt outputs: level, high while any enabled bit is latched
    // combinational so an enabled set shows one cycle after its event; see [R13]
    always_comb begin
        interrupt_output_primary_o = |{lvl3_status & lvl3_mask1,
                                       lvl4_status & lvl4_mask1,
                                       edge1_status & edge1_mask1};
        interrupt_output_secondary_o = |{lvl3_status & lvl3_mask2,
                                         lvl4_status & lvl4_mask2,
                                         edge1_status & edge1_mask2};
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data stands only in the cycle after the strobe
    // clear registers are write only and read as zero; reads have no side effect
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            RXIS_OFF_LVL3_STATUS: begin
                next_rdata = lvl3_status; // see [R12]
            end
            RXIS_OFF_LVL4_STATUS: begin
                next_rdata = lvl4_status;
            end
            RXIS_OFF_EDGE1_STATUS: begin
                next_rdata = edge1_status;
            end
            RXIS_OFF_LVL3_LIVE: begin
                next_rdata = {2'b00, level_live_i[5:0]};
            end
            RXIS_OFF_LVL4_LIVE: begin
                next_rdata = {5'b00000, level_live_i[8:6]};
            end
            RXIS_OFF_LVL3_MASK1: begin
                next_rdata = lvl3_mask1;
            end
            RXIS_OFF_LVL4_MASK1: begin
                next_rdata = lvl4_mask1;
            end
            RXIS_OFF_EDGE1_MASK1: begin
                next_rdata = edge1_mask1;
            end
            RXIS_OFF_LVL3_MASK2: begin
                next_rdata = lvl3_mask2;
            end
            RXIS_OFF_LVL4_MASK2: begin
                next_rdata = lvl4_mask2;
            end
            RXIS_OFF_EDGE1_MASK2: begin
                next_rdata = edge1_mask2;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_pll_b_latch: assert property ( // see [R1]
        armed && level_live_i.port_b_pll_lock_live != $past(level_live_i.port_b_pll_lock_live)
        |=> lvl3_status[RXIS_POS_PLL_B])
        else $error("port b pll lock change not latched");

    a_clk_a_latch: assert property ( // see [R2]
        armed && level_live_i.port_a_clock_detect_live != $past(level_live_i.port_a_clock_detect_live)
        |=> lvl3_status[RXIS_POS_CLK_A])
        else $error("port a clock detect change not latched");

    a_clk_b_latch: assert property ( // see [R3]
        armed && level_live_i.port_b_clock_detect_live != $past(level_live_i.port_b_clock_detect_live)
        |=> lvl3_status[RXIS_POS_CLK_B])
        else $error("port b clock detect change not latched");

    a_stereo_latch: assert property ( // see [R4]
        armed && $rose(level_live_i.stereo_video_live)
        |=> lvl3_status[RXIS_POS_STEREO] ##1 lvl3_status[RXIS_POS_STEREO] || $past(lvl3_clr[RXIS_POS_STEREO]))
        else $error("stereo video change not latched");

    a_vsync_fall: assert property ( // see [R5] [R14]
        armed && $fell(level_live_i.vsync_filter_lock_live)
        |=> lvl3_status[RXIS_POS_VSYNC])
        else $error("falling vsync lock not latched");

    a_regen_latch: assert property ( // see [R6] [R14]
        armed && level_live_i.enable_regen_lock_live != $past(level_live_i.enable_regen_lock_live)
        |=> lvl3_status[RXIS_POS_REGEN])
        else $error("enable regen lock change not latched");

    a_encr_a_latch: assert property ( // see [R7]
        armed && level_live_i.port_a_encryption_live != $past(level_live_i.port_a_encryption_live)
        |=> lvl4_status[RXIS_POS_ENCR_A])
        else $error("port a encryption change not latched");

    a_encr_b_latch: assert property ( // see [R8]
        armed && level_live_i.port_b_encryption_live != $past(level_live_i.port_b_encryption_live)
        |=> lvl4_status[RXIS_POS_ENCR_B])
        else $error("port b encryption change not latched");

    a_cable_a_latch: assert property ( // see [R9]
        armed && level_live_i.port_a_cable_present_live != $past(level_live_i.port_a_cable_present_live)
        |=> lvl4_status[RXIS_POS_CABLE_A])
        else $error("port a cable change not latched");

    a_code2_set: assert property ( // see [R10]
        armed && packet_new_i.second_recording_code_pkt_new |=> edge1_status[RXIS_POS_CODE2])
        else $error("second code packet not latched");

    a_code1_set: assert property ( // see [R11]
        armed && packet_new_i.first_recording_code_pkt_new |=> edge1_status[RXIS_POS_CODE1])
        else $error("first code packet not latched");

    a_sticky_hold: assert property ( // see [R12]
        ((($past(lvl3_status) & ~$past(lvl3_clr)) & ~lvl3_status) == 8'h00)
        && ((($past(edge1_status) & ~$past(edge1_clr)) & ~edge1_status) == 8'h00))
        else $error("status bit dropped without a clear");

    a_read_keeps: assert property ( // see [R12]
        reg_rd_i && reg_addr_i == RXIS_OFF_LVL4_STATUS && lvl4_status != 8'h00
        |=> ((lvl4_status & $past(lvl4_status)) == $past(lvl4_status))
            && reg_rdata_o == $past(lvl4_status))
        else $error("status read lost or altered a bit");

    a_mask_gates: assert property ( // see [R13]
        reg_wr_i && reg_addr_i == RXIS_OFF_LVL3_MASK2 && (reg_wdata_i & lvl3_status) != 8'h00
        |=> interrupt_output_secondary_o)
        else $error("enabled bit did not raise secondary interrupt");

    a_masked_quiet: assert property ( // see [R13]
        $past(lvl3_mask1 == 8'h00 && lvl4_mask1 == 8'h00 && edge1_mask1 == 8'h00)
        && lvl3_mask1 == 8'h00 && lvl4_mask1 == 8'h00 && edge1_mask1 == 8'h00
        |-> !interrupt_output_primary_o)
        else $error("primary interrupt with all masks off");

    a_clear_next: assert property ( // see [R15]
        lvl3_clr[RXIS_POS_PLL_B] && !lvl3_set[RXIS_POS_PLL_B] |=> !lvl3_status[RXIS_POS_PLL_B])
        else $error("clear did not act on next edge");

    a_set_wins: assert property ( // see [R15]
        edge1_clr[RXIS_POS_CODE1] && edge1_set[RXIS_POS_CODE1] |=> edge1_status[RXIS_POS_CODE1] [*2])
        else $error("event lost against clear");

    ////////////////////////////////////////////////////////////////////////
    // further guards on the read port, level four hold and clear, both edges, secondary masks, reserved bits and the priming cycle

    a_rdata_idle: assert property ( // see [R12]
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data stood outside its cycle");

    a_lvl4_sticky: assert property ( // see [R12]
        (($past(lvl4_status) & ~$past(lvl4_clr)) & ~lvl4_status) == 8'h00)
        else $error("level four status bit dropped without a clear");

    a_stereo_fall: assert property ( // see [R4] [R14]
        armed && $fell(level_live_i.stereo_video_live)
        |=> lvl3_status[RXIS_POS_STEREO])
        else $error("falling stereo video not latched");

    a_vsync_rise: assert property ( // see [R5] [R14]
        armed && $rose(level_live_i.vsync_filter_lock_live)
        |=> lvl3_status[RXIS_POS_VSYNC])
        else $error("rising vsync lock not latched");

    a_reserved_zero: assert property ( // see [R12]
        (lvl3_status & ~RXIS_LVL3_VALID) == 8'h00
        && (lvl4_status & ~RXIS_LVL4_VALID) == 8'h00
        && (edge1_status & ~RXIS_EDGE1_VALID) == 8'h00)
        else $error("reserved status bit set");

    // the priming edge must not raise anything, whatever the levels are
    a_prime_quiet: assert property ( // see [R14]
        !armed |=> lvl3_status == 8'h00 && lvl4_status == 8'h00 && edge1_status == 8'h00)
        else $error("event raised on the priming edge");

    a_secondary_quiet: assert property ( // see [R13]
        $past(lvl3_mask2 == 8'h00 && lvl4_mask2 == 8'h00 && edge1_mask2 == 8'h00)
        && lvl3_mask2 == 8'h00 && lvl4_mask2 == 8'h00 && edge1_mask2 == 8'h00
        |-> !interrupt_output_secondary_o)
        else $error("secondary interrupt with all masks off");

    a_clear_lvl4: assert property ( // see [R15]
        lvl4_clr[RXIS_POS_CABLE_A] && !lvl4_set[RXIS_POS_CABLE_A]
        |=> !lvl4_status[RXIS_POS_CABLE_A])
        else $error("level four clear did not act on next edge");

    c_level_irq: cover property (
        armed && $changed(level_live_i.port_a_cable_present_live) ##1 interrupt_output_primary_o);

    c_set_clear_same: cover property (lvl3_clr != 8'h00 && (lvl3_clr & lvl3_set) != 8'h00);

    c_status_read: cover property (reg_rd_i && reg_addr_i == RXIS_OFF_EDGE1_STATUS ##1 reg_rdata_o != 8'h00);

    c_both_irq: cover property (interrupt_output_primary_o && interrupt_output_secondary_o);

endmodule

`default_nettype wire

// ==== dv/tb_rxis_status_latches.sv ====
/*
 * tb_rxis_status_latches: self-checking bench for the receiver interrupt
 * status latches. Drives levels, packet pulses and the register port itself.
 * Assumes the package offsets and the one-cycle read latency of the design.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_rxis_status_latches;
    import rxis_pkg::*;

    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    rxis_level_s lvl = '0;
    rxis_packet_s pkt = '0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata_o;
    logic irq1_o;
    logic irq2_o;
    int mismatches = 0;
    int checked = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    rxis_status_latches i_rxis_status_latches (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .level_live_i(lvl),
        .packet_new_i(pkt),
        .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata_o),
        .interrupt_output_primary_o(irq1_o),
        .interrupt_output_secondary_o(irq2_o)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // strobes last one cycle; the edge after raising is the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk_i);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk_i);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata_o, exp, "read data");
    endtask

    // flip one live level; the following edge sees the change
    task automatic toggle(input int i);
        @(posedge ref_clk_i);
        lvl[i] <= ~lvl[i];
        @(posedge ref_clk_i);
        #1;
    endtask

    task automatic pulse(input int j);
        @(posedge ref_clk_i);
        pkt[j] <= 1'b1;
        @(posedge ref_clk_i);
        pkt[j] <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        rd_chk(RXIS_OFF_LVL3_STATUS, RXIS_RST_STATUS);
        rd_chk(RXIS_OFF_LVL4_STATUS, RXIS_RST_STATUS);
        rd_chk(RXIS_OFF_EDGE1_STATUS, RXIS_RST_STATUS);
        rd_chk(RXIS_OFF_LVL3_MASK1, RXIS_RST_MASK);
        rd_chk(RXIS_OFF_EDGE1_MASK2, RXIS_RST_MASK);
        rd_chk(8'h00, 8'h00);
        chk({7'h00, irq1_o}, 8'h00, "irq1 after reset");
    endtask

    // every level bit latches on a rise and again on a fall
    task automatic t_level_bits();
        logic [7:0] st;
        logic [7:0] cl;
        logic [7:0] b;
        for (int i = 0; i < 9; i++) begin
            st = (i < 6) ? RXIS_OFF_LVL3_STATUS : RXIS_OFF_LVL4_STATUS;
            cl = (i < 6) ? RXIS_OFF_LVL3_CLEAR : RXIS_OFF_LVL4_CLEAR;
            b = 8'h01 << ((i < 6) ? i : i - 6);
            toggle(i);
            rd_chk(st, b);
            repeat (3) @(posedge ref_clk_i);
            rd_chk(st, b);
            wr(cl, b);
            rd_chk(st, 8'h00);
            toggle(i);
            rd_chk(st, b);
            wr(cl, b);
            rd_chk(st, 8'h00);
        end
    endtask

    // packet pulses, masks driving both outputs, clear dropping them
    task automatic t_packets_irq();
        pulse(1);
        rd_chk(RXIS_OFF_EDGE1_STATUS, 8'h80);
        chk({6'h00, irq2_o, irq1_o}, 8'h00, "irq with masks off");
        wr(RXIS_OFF_EDGE1_MASK1, 8'h80);
        chk({6'h00, irq2_o, irq1_o}, 8'h01, "irq1 enabled");
        wr(RXIS_OFF_EDGE1_MASK2, 8'h40);
        chk({6'h00, irq2_o, irq1_o}, 8'h01, "irq2 other bit");
        pulse(0);
        rd_chk(RXIS_OFF_EDGE1_STATUS, 8'hc0);
        chk({6'h00, irq2_o, irq1_o}, 8'h03, "both irqs");
        wr(RXIS_OFF_EDGE1_CLEAR, 8'h80);
        chk({6'h00, irq2_o, irq1_o}, 8'h02, "irq1 cleared");
        wr(RXIS_OFF_EDGE1_CLEAR, 8'h40);
        chk({6'h00, irq2_o, irq1_o}, 8'h00, "irq2 cleared");
        rd_chk(RXIS_OFF_EDGE1_MASK1, 8'h80);
    endtask

    // event in the same cycle as its clear must survive
    task automatic t_set_beats_clear();
        @(posedge ref_clk_i);
        reg_wr <= 1'b1;
        reg_addr <= RXIS_OFF_EDGE1_CLEAR;
        reg_wdata <= 8'h40;
        pkt[0] <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr <= 1'b0;
        pkt[0] <= 1'b0;
        #1;
        chk({6'h00, irq2_o, irq1_o}, 8'h02, "irq2 kept");
        rd_chk(RXIS_OFF_EDGE1_STATUS, 8'h40);
        wr(RXIS_OFF_EDGE1_CLEAR, 8'h40);
        rd_chk(RXIS_OFF_EDGE1_STATUS, 8'h00);
    endtask

    // read-only and reserved places ignore writes
    task automatic t_refusals();
        wr(RXIS_OFF_LVL3_STATUS, 8'hff);
        rd_chk(RXIS_OFF_LVL3_STATUS, 8'h00);
        wr(RXIS_OFF_LVL4_MASK2, 8'hff);
        rd_chk(RXIS_OFF_LVL4_MASK2, RXIS_LVL4_VALID);
        rd_chk(RXIS_OFF_LVL4_CLEAR, 8'h00);
        toggle(8);
        chk({7'h00, irq2_o}, 8'h01, "level irq2");
        wr(RXIS_OFF_LVL4_CLEAR, 8'h04);
        chk({7'h00, irq2_o}, 8'h00, "level irq2 cleared");
        rd_chk(8'hff, 8'h00);
    endtask

    // live readback, read data standing one cycle, primary output on level bits
    // entry state: only the port a encryption level is high, all status clear
    task automatic t_live_stand();
        @(posedge ref_clk_i);
        lvl <= 9'h1a5;
        @(posedge ref_clk_i);
        #1;
        rd_chk(RXIS_OFF_LVL3_LIVE, 8'h25);
        rd_chk(RXIS_OFF_LVL4_LIVE, 8'h06);
        rd_chk(RXIS_OFF_LVL3_STATUS, 8'h25);
        @(posedge ref_clk_i);
        #1;
        chk(reg_rdata_o, 8'h00, "read data after its cycle");
        rd_chk(RXIS_OFF_LVL4_STATUS, 8'h02);
        chk({7'h00, irq1_o}, 8'h00, "irq1 level masks off");
        wr(RXIS_OFF_LVL3_MASK1, 8'h20);
        chk({7'h00, irq1_o}, 8'h01, "irq1 level enabled");
        wr(RXIS_OFF_LVL3_CLEAR, 8'h3f);
        chk({7'h00, irq1_o}, 8'h00, "irq1 level cleared");
        wr(RXIS_OFF_LVL4_CLEAR, 8'h07);
        rd_chk(RXIS_OFF_LVL3_STATUS, 8'h00);
        rd_chk(RXIS_OFF_LVL4_STATUS, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        t_reset_values();
        t_level_bits();
        t_packets_irq();
        t_set_beats_clear();
        t_refusals();
        t_live_stand();
        results();
    end

    // the whole sequence is a few hundred cycles; this is far beyond it
    initial begin
        #200000;
        mismatches++;
        results();
    end

endmodule

`default_nettype wire
